// File: tb/gated_timer_asserts.sv
// port-level checker of the gated timer
`timescale 1ns/1ps
module gated_timer_asserts (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        irq,
  input wire logic [2:0]  irq_priority,
  input wire logic        match_tick
);
  // ==========================================================
  // address phase tracking
  logic ap;
  logic wok;
  logic rd_q;
  logic rd_ctl_q;
  logic wr_cfg_q;
  logic wr_msk_q;
  assign ap  = hsel && hready && (htrans == gated_timer_pkg::HTRANS_NONSEQ);
  assign wok = ap && hwrite && (hsize == gated_timer_pkg::HSIZE_WORD);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q     <= 1'b0;
      rd_ctl_q <= 1'b0;
      wr_cfg_q <= 1'b0;
      wr_msk_q <= 1'b0;
    end else begin
      rd_q     <= ap && !hwrite;
      rd_ctl_q <= ap && !hwrite && (haddr[7:0] == gated_timer_pkg::OFS_CONTROL);
      wr_cfg_q <= wok && (haddr[7:0] == gated_timer_pkg::OFS_IRQ_CONFIG);
      wr_msk_q <= wok && (haddr[7:0] == gated_timer_pkg::OFS_IRQ_MASK);
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // properties
  chk_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  chk_rdata_quiet: assert property (!rd_q |-> hrdata == 32'h0000_0000)
    else $error("hrdata outside read data phase");
  chk_rdata_upper: assert property (rd_q |-> hrdata[31:16] == 16'h0000)
    else $error("upper read data bits set");
  chk_ctl_zero: assert property (rd_ctl_q |-> hrdata[31:16] == 16'h0000 && !hrdata[14]
    && hrdata[12:7] == 6'h00 && !hrdata[3] && !hrdata[0]) else $error("unused control bit set");
  chk_prio_copy: assert property (wr_cfg_q |-> ##2 irq_priority == $past(hwdata[3:1], 2))
    else $error("priority not taken");
  chk_mask_quiet: assert property (wr_msk_q && hwdata[1:0] == 2'b00 |-> ##2 !irq)
    else $error("irq with all masked");
  chk_tick_pulse: assert property ($rose(match_tick) |=> !match_tick)
    else $error("match tick too long");
  chk_reset_quiet: assert property ($rose(hresetn) |-> !irq && !match_tick
    && irq_priority == 3'h0) else $error("outputs active after reset");
endmodule

bind gated_timer gated_timer_asserts chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq),
  .irq_priority(irq_priority), .match_tick(match_tick)
);

// File: tb/pin_stimulus.sv
// model of the external count clock and gate pins
`timescale 1ns/1ps
module pin_stimulus (
  input  wire logic hclk,
  output logic      ext_clk_pin,
  output logic      gate_pin
);
  initial begin
    ext_clk_pin = 1'b0;
    gate_pin    = 1'b0;
  end
  // slow pulses so both sync and raw paths see every edge
  task pulses(input int n);
    repeat (n) begin
      @(posedge hclk);
      ext_clk_pin <= 1'b1;
      repeat (4) @(posedge hclk);
      ext_clk_pin <= 1'b0;
      repeat (3) @(posedge hclk);
    end
  endtask
  task gate_high(input int n);
    @(posedge hclk);
    gate_pin <= 1'b1;
    repeat (n) @(posedge hclk);
    gate_pin <= 1'b0;
  endtask
endmodule

// File: tb/tb_top.sv
// register-level testbench of the gated timer
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] CTL = 8'h00;
  localparam logic [7:0] PER = 8'h04;
  localparam logic [7:0] CNT = 8'h08;
  localparam logic [7:0] STS = 8'h0C;
  localparam logic [7:0] MSK = 8'h10;
  localparam logic [7:0] CFG = 8'h14;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        cpu_idle, cpu_sleep, irq, match_tick, ext_clk_pin, gate_pin;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, irq_priority;
  int          err_total, n_checks, i, n_ticks;
  int          rat[4] = '{1, 8, 64, 256};
  assign hready = hreadyout;
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  gated_timer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ext_clk_pin(ext_clk_pin),
    .gate_pin(gate_pin), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .irq(irq),
    .irq_priority(irq_priority), .match_tick(match_tick));
  pin_stimulus ext_pins (.hclk(hclk), .ext_clk_pin(ext_clk_pin), .gate_pin(gate_pin));
  // cycles in which the time base pulse stands
  always @(posedge hclk) begin
    if (match_tick === 1'b1)
      n_ticks++;
  end
  // ==========================================================
  // reporting
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ==========================================================
  // bus master
  task wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      err_total++;
      $display("bus wait ran out");
      end_of_test;
    end
  endtask
  task addr_ph(input logic [7:0] a, input logic w);
    @(posedge hclk);
    htrans <= gated_timer_pkg::HTRANS_NONSEQ;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    wait_rdy;
    htrans <= 2'b00;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    addr_ph(a, 1'b1);
    hwdata <= d;
    wait_rdy;
  endtask
  task rdr(input logic [7:0] a);
    addr_ph(a, 1'b0);
    wait_rdy;
    rd = hrdata;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    rdr(a);
    check(what, rd, exp);
  endtask
  task wait_irq;
    i = 0;
    while (irq !== 1'b1 && i < 100) begin
      @(posedge hclk);
      i++;
    end
    if (irq !== 1'b1) begin
      err_total++;
      $display("irq wait ran out");
      end_of_test;
    end
  endtask
  // ==========================================================
  // test sequence
  initial begin
    hresetn = 1'b0; hsel = 1'b1; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = gated_timer_pkg::HSIZE_WORD; hwdata = 32'h0; cpu_idle = 1'b0; cpu_sleep = 1'b0;
    err_total = 0; n_checks = 0;
    n_ticks = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(CTL, 32'h0, "control reset");
    rchk(PER, 32'hFFFF, "period reset");
    rchk(CNT, 32'h0, "count reset");
    rchk(STS, 32'h0, "status reset");
    rchk(MSK, 32'h0, "mask reset");
    rchk(8'h18, 32'h0, "unmapped");
    wr(CTL, 32'hFFFF_FFFF);
    rchk(CTL, 32'h0000_A076, "control bits");
    wr(CTL, 32'h0);
    $display("test registers done");
    wr(CNT, 32'h0); wr(PER, 32'h2); wr(MSK, 32'h3); wr(CFG, 32'hF); wr(CTL, 32'h8000);
    wait_irq;
    check("irq raised", {31'h0, irq}, 32'h1);
    check("priority", {29'h0, irq_priority}, 32'h7);
    wr(CTL, 32'h0);
    rdr(CNT);
    check("count wraps", {31'h0, rd <= 32'h2}, 32'h1);
    check("match tick", {31'h0, n_ticks > 0}, 32'h1);
    wr(MSK, 32'h0);
    @(posedge hclk);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(MSK, 32'h3);
    repeat (2) @(posedge hclk);
    check("irq unmasked", {31'h0, irq}, 32'h1);
    rchk(STS, 32'h1, "match flag");
    rchk(STS, 32'h0, "flag cleared");
    check("irq cleared", {31'h0, irq}, 32'h0);
    wr(PER, 32'hFFFF);
    $display("test match done");
    for (int c = 1; c < 4; c++) begin
      wr(CNT, 32'h0);
      wr(CTL, 32'h8000 | (c << 4));
      repeat (4 * rat[c] + rat[c] / 2) @(posedge hclk);
      wr(CTL, 32'h0);
      rchk(CNT, 32'h4, "prescaled count");
    end
    $display("test prescaler done");
    wr(CNT, 32'h0);
    cpu_idle <= 1'b1;
    wr(CTL, 32'hA000);
    repeat (50) @(posedge hclk);
    wr(CTL, 32'h0);
    rchk(CNT, 32'h0, "stopped in idle");
    wr(CTL, 32'h8000);
    repeat (50) @(posedge hclk);
    wr(CTL, 32'h0);
    rdr(CNT);
    check("runs in idle", {31'h0, rd > 32'd40}, 32'h1);
    cpu_idle <= 1'b0;
    $display("test idle done");
    wr(CNT, 32'h0);
    wr(CTL, 32'h8006);
    ext_pins.pulses(10);
    repeat (8) @(posedge hclk);
    wr(CTL, 32'h0);
    rchk(CNT, 32'hA, "sync ext count");
    wr(CNT, 32'h0);
    cpu_sleep <= 1'b1;
    wr(CTL, 32'h8006);
    ext_pins.pulses(3);
    wr(CTL, 32'h0);
    rchk(CNT, 32'h0, "sync halts in sleep");
    wr(CTL, 32'h8042);
    ext_pins.pulses(10);
    repeat (8) @(posedge hclk);
    wr(CTL, 32'h0);
    rchk(CNT, 32'hA, "async ext count");
    cpu_sleep <= 1'b0;
    $display("test external done");
    wr(CNT, 32'h0);
    wr(CTL, 32'h8040);
    repeat (10) @(posedge hclk);
    ext_pins.gate_high(40);
    repeat (8) @(posedge hclk);
    wr(CTL, 32'h0);
    rdr(CNT);
    check("gated count", {31'h0, rd >= 32'd38 && rd <= 32'd42}, 32'h1);
    rchk(STS, 32'h2, "gate fall flag");
    $display("test gate done");
    end_of_test;
  end
endmodule

// File: verilog/gated_timer.sv
// 16-bit gated timer/counter with period match and AHB-Lite registers
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps

// Overview of operation
// - one 16-bit count register serves as interval timer/counter or as a time base tick.
// - modes are internal timer, synchronised external counter and raw external counter.
// - the flag rises on a period match, or in gated mode on a falling gate edge.
// - the timer may keep counting while the processor is in idle or sleep.
// - the match compares against a period register loaded by software.
// - control bits 5 and 4 choose the prescaler ratio applied to the selected clock.
// - bit 2 chooses synchronised or unsynchronised external clock counting.
// - bit 13 halts the timer in idle when 1 and lets it run when 0.
// - with the internal clock, bit 6 turns gated accumulation on when 1.
// - with the external clock selected, bit 6 has no effect.
// - the sync bit acts only with the external clock and is ignored otherwise.
module gated_timer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        ext_clk_pin,
  input  wire logic        gate_pin,
  input  wire logic        cpu_idle,
  input  wire logic        cpu_sleep,
  output logic             irq,
  output logic [2:0]       irq_priority,
  output logic             match_tick
);

  // ==========================================================
  // state
  gated_timer_pkg::control_s              ctrl_reg;
  gated_timer_pkg::control_s              ctrl_next;
  gated_timer_pkg::bus_phase_s            phase_reg;
  gated_timer_pkg::bus_phase_s            phase_next;
  logic [15:0]                            period_reg;
  logic [15:0]                            period_next;
  logic [15:0]                            count_reg;
  logic [15:0]                            count_next;
  logic [gated_timer_pkg::IRQ_EVENTS-1:0] status_reg;
  logic [gated_timer_pkg::IRQ_EVENTS-1:0] status_next;
  logic [gated_timer_pkg::IRQ_EVENTS-1:0] mask_reg;
  logic [gated_timer_pkg::IRQ_EVENTS-1:0] mask_next;
  logic [gated_timer_pkg::IRQ_EVENTS-1:0] event_set;
  logic [gated_timer_pkg::IRQ_EVENTS-1:0] status_clr;
  logic                                   irq_enable_reg;
  logic                                   irq_enable_next;
  logic [2:0]                             irq_priority_reg;
  logic [2:0]                             irq_priority_next;
  logic [31:0]                            hrdata_reg;
  logic [31:0]                            hrdata_next;
  logic                                   irq_reg;
  logic                                   irq_next;
  logic                                   match_tick_reg;
  logic                                   match_tick_next;
  logic                                   ready_reg;

  // timing path
  logic                                   ext_rise_sync;
  logic                                   ext_rise_async;
  logic                                   gate_fall;
  logic                                   ext_tick;
  logic                                   src_tick;
  logic                                   run_allowed;
  logic                                   pre_tick_in;
  logic                                   count_tick;
  logic                                   take_addr;
  logic                                   wr_word;
  logic                                   is_match;
  logic [15:0]                            ctrl_view;

  // ==========================================================
  // pin edges and prescaler
  pin_edge_detect u_pins (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .ext_clk_pin    (ext_clk_pin),
    .gate_pin       (gate_pin),
    .ext_rise_sync  (ext_rise_sync),
    .ext_rise_async (ext_rise_async),
    .gate_fall      (gate_fall)
  );

  // prescaler cleared while off, so every start begins a full ratio
  tick_prescaler u_prescale (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .clear           (~ctrl_reg.timer_on),
    .prescale_select (ctrl_reg.prescale_select),
    .tick_in         (pre_tick_in),
    .tick_out        (count_tick)
  );

  // ==========================================================
  // clock source, gating and power modes
  always_comb begin
    // only looked at with the external clock
    ext_tick = ctrl_reg.ext_clock_sync_select ? ext_rise_sync : ext_rise_async;
    if (ctrl_reg.clock_source_select) begin
      src_tick = ext_tick;
    end else if (ctrl_reg.gate_accum_enable) begin
      src_tick = gate_pin;
    end else begin
      src_tick = 1'b1;
    end
    // sleep stops the core clock, so only the raw external path survives
    run_allowed = ctrl_reg.timer_on
                & ~(cpu_idle & ctrl_reg.stop_in_idle)
                & ~(cpu_sleep & ~(ctrl_reg.clock_source_select
                                  & ~ctrl_reg.ext_clock_sync_select));
    pre_tick_in = src_tick & run_allowed;
  end

  // ==========================================================
  // bus address phase
  always_comb begin
    take_addr  = hsel & hready & (htrans == gated_timer_pkg::HTRANS_NONSEQ);
    phase_next = '0;
    if (take_addr) begin
      phase_next.active = 1'b1;
      phase_next.write  = hwrite & (hsize == gated_timer_pkg::HSIZE_WORD);
      phase_next.addr   = haddr[7:0];
    end
    // writes land at the data phase edge; a read in that cycle sees the old value
    wr_word = phase_reg.active & phase_reg.write;
  end

  always_comb begin
    ctrl_view = 16'h0000;
    ctrl_view[gated_timer_pkg::BIT_TIMER_ON]     = ctrl_reg.timer_on;
    ctrl_view[gated_timer_pkg::BIT_STOP_IN_IDLE] = ctrl_reg.stop_in_idle;
    ctrl_view[gated_timer_pkg::BIT_GATE_ACCUM]   = ctrl_reg.gate_accum_enable;
    ctrl_view[gated_timer_pkg::BIT_PRESCALE_HI:gated_timer_pkg::BIT_PRESCALE_LO] =
      ctrl_reg.prescale_select;
    ctrl_view[gated_timer_pkg::BIT_EXT_SYNC]     = ctrl_reg.ext_clock_sync_select;
    ctrl_view[gated_timer_pkg::BIT_CLOCK_SOURCE] = ctrl_reg.clock_source_select;
  end

  // ==========================================================
  // read data, captured at the address phase so it leaves a flop
  always_comb begin
    hrdata_next = 32'h0000_0000;
    status_clr  = '0;
    if (take_addr && !hwrite) begin
      unique case (haddr[7:0])
        gated_timer_pkg::OFS_CONTROL:    hrdata_next = {16'h0000, ctrl_view};
        gated_timer_pkg::OFS_PERIOD:     hrdata_next = {16'h0000, period_reg};
        gated_timer_pkg::OFS_COUNT:      hrdata_next = {16'h0000, count_reg};
        gated_timer_pkg::OFS_IRQ_STATUS: begin
          // only the bits shown are cleared, so no set is lost unseen
          hrdata_next[gated_timer_pkg::IRQ_EVENTS-1:0] = status_reg;
          status_clr = status_reg;
        end
        gated_timer_pkg::OFS_IRQ_MASK:
          hrdata_next[gated_timer_pkg::IRQ_EVENTS-1:0] = mask_reg;
        gated_timer_pkg::OFS_IRQ_CONFIG: begin
          hrdata_next[gated_timer_pkg::BIT_IRQ_ENABLE] = irq_enable_reg;
          hrdata_next[gated_timer_pkg::BIT_IRQ_PRIO_LO +: 3] = irq_priority_reg;
        end
        default: hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // register writes (data phase)
  always_comb begin
    ctrl_next         = ctrl_reg;
    period_next       = period_reg;
    mask_next         = mask_reg;
    irq_enable_next   = irq_enable_reg;
    irq_priority_next = irq_priority_reg;
    if (wr_word) begin
      unique case (phase_reg.addr)
        gated_timer_pkg::OFS_CONTROL: begin
          ctrl_next.timer_on          = hwdata[gated_timer_pkg::BIT_TIMER_ON];
          ctrl_next.stop_in_idle      = hwdata[gated_timer_pkg::BIT_STOP_IN_IDLE];
          ctrl_next.gate_accum_enable = hwdata[gated_timer_pkg::BIT_GATE_ACCUM];
          // code stored as written, decoded in the prescaler
          ctrl_next.prescale_select   =
            hwdata[gated_timer_pkg::BIT_PRESCALE_HI:gated_timer_pkg::BIT_PRESCALE_LO];
          ctrl_next.ext_clock_sync_select = hwdata[gated_timer_pkg::BIT_EXT_SYNC];
          ctrl_next.clock_source_select   = hwdata[gated_timer_pkg::BIT_CLOCK_SOURCE];
        end
        gated_timer_pkg::OFS_PERIOD:   period_next = hwdata[15:0];
        gated_timer_pkg::OFS_IRQ_MASK:
          mask_next = hwdata[gated_timer_pkg::IRQ_EVENTS-1:0];
        // interrupt enable and priority set last by software
        gated_timer_pkg::OFS_IRQ_CONFIG: begin
          irq_enable_next   = hwdata[gated_timer_pkg::BIT_IRQ_ENABLE];
          irq_priority_next = hwdata[gated_timer_pkg::BIT_IRQ_PRIO_LO +: 3];
        end
        default: ctrl_next = ctrl_reg;
      endcase
    end
  end

  // ==========================================================
  // counter and events
  always_comb begin
    // compare against period
    // compare before the increment, so the period value itself is counted
    is_match = (count_reg == period_reg);
    count_next = count_reg;
    // wrap to zero on the increment after a match
    if (count_tick) begin
      count_next = is_match ? 16'h0000 : count_reg + 16'h0001;
    end
    // software write to the count wins over a tick in the same cycle
    if (wr_word && phase_reg.addr == gated_timer_pkg::OFS_COUNT) begin
      count_next = hwdata[15:0];
    end
    event_set = '0;
    event_set[gated_timer_pkg::BIT_IRQ_MATCH] = count_tick & is_match;
    event_set[gated_timer_pkg::BIT_IRQ_GATE_FALL] =
      gate_fall & ctrl_reg.timer_on & ctrl_reg.gate_accum_enable
      & ~ctrl_reg.clock_source_select;
    // a set in the clearing cycle survives
    status_next     = (status_reg & ~status_clr) | event_set;
    irq_next        = irq_enable_next & (|(status_next & mask_next));
    match_tick_next = event_set[gated_timer_pkg::BIT_IRQ_MATCH];
  end

  // ==========================================================
  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // implemented control bits reset to zero
      ctrl_reg         <= '0;
      phase_reg        <= '0;
      // all ones keeps the match far away until software loads a period
      period_reg       <= gated_timer_pkg::RST_PERIOD;
      count_reg        <= gated_timer_pkg::RST_COUNT;
      status_reg       <= '0;
      mask_reg         <= '0;
      irq_enable_reg   <= 1'b0;
      irq_priority_reg <= 3'h0;
      hrdata_reg       <= 32'h0000_0000;
      irq_reg          <= 1'b0;
      match_tick_reg   <= 1'b0;
    end else begin
      ctrl_reg         <= ctrl_next;
      phase_reg        <= phase_next;
      period_reg       <= period_next;
      count_reg        <= count_next;
      status_reg       <= status_next;
      mask_reg         <= mask_next;
      irq_enable_reg   <= irq_enable_next;
      irq_priority_reg <= irq_priority_next;
      hrdata_reg       <= hrdata_next;
      irq_reg          <= irq_next;
      match_tick_reg   <= match_tick_next;
    end
  end

  // zero wait states and always OKAY: a constant-reset flop keeps outputs registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_reg <= 1'b1;
    end else begin
      ready_reg <= 1'b1;
    end
  end

  // ==========================================================
  // outputs
  // copies of flops: only the inverter on hresp sits between a register and a pin
  always_comb begin
    hreadyout    = ready_reg;
    hresp        = ~ready_reg;
    hrdata       = hrdata_reg;
    irq          = irq_reg;
    irq_priority = irq_priority_reg;
    match_tick   = match_tick_reg;
  end

endmodule

// File: verilog/gated_timer_pkg.sv
// constants, field layouts and carrier types of the gated timer
package gated_timer_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFS_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_PERIOD     = 8'h04;
  localparam logic [7:0] OFS_COUNT      = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h10;
  localparam logic [7:0] OFS_IRQ_CONFIG = 8'h14;

  // ==========================================================
  // control register field positions
  localparam int BIT_TIMER_ON     = 15;
  localparam int BIT_STOP_IN_IDLE = 13;
  localparam int BIT_GATE_ACCUM   = 6;
  localparam int BIT_PRESCALE_HI  = 5;
  localparam int BIT_PRESCALE_LO  = 4;
  localparam int BIT_EXT_SYNC     = 2;
  localparam int BIT_CLOCK_SOURCE = 1;

  // irq status / mask layout
  localparam int BIT_IRQ_MATCH     = 0;
  localparam int BIT_IRQ_GATE_FALL = 1;
  localparam int IRQ_EVENTS        = 2;

  // irq config layout
  localparam int BIT_IRQ_ENABLE   = 0;
  localparam int BIT_IRQ_PRIO_LO  = 1;

  // ==========================================================
  // reset values
  localparam logic [15:0] RST_PERIOD = 16'hFFFF;
  localparam logic [15:0] RST_COUNT  = 16'h0000;

  // ==========================================================
  // prescaler terminal counts (ratio minus one)
  localparam logic [7:0] PRESCALE_LIM_1   = 8'h00;
  localparam logic [7:0] PRESCALE_LIM_8   = 8'h07;
  localparam logic [7:0] PRESCALE_LIM_64  = 8'h3F;
  localparam logic [7:0] PRESCALE_LIM_256 = 8'hFF;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD    = 3'b010;

  typedef struct packed {
    logic       timer_on;
    logic       stop_in_idle;
    logic       gate_accum_enable;
    logic [1:0] prescale_select;
    logic       ext_clock_sync_select;
    logic       clock_source_select;
  } control_s;

  typedef struct packed {
    logic       active;
    logic       write;
    logic [7:0] addr;
  } bus_phase_s;

endpackage

// File: verilog/pin_edge_detect.sv
// edge detection of the external clock and gate pins
`timescale 1ns/1ps
module pin_edge_detect (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ext_clk_pin,
  input  wire logic gate_pin,
  output logic      ext_rise_sync,
  output logic      ext_rise_async,
  output logic      gate_fall
);

  logic ext_s1_reg, ext_s2_reg, ext_s3_reg, ext_raw_reg, gate_reg;

  // ==========================================================
  // edges
  // synced path adds two cycles of latency, raw path reacts at once
  always_comb begin
    ext_rise_sync  = ext_s2_reg & ~ext_s3_reg;
    ext_rise_async = ext_clk_pin & ~ext_raw_reg;
    gate_fall      = gate_reg & ~gate_pin;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_reg  <= 1'b0;
      ext_s2_reg  <= 1'b0;
      ext_s3_reg  <= 1'b0;
      ext_raw_reg <= 1'b0;
      gate_reg    <= 1'b0;
    end else begin
      ext_s1_reg  <= ext_clk_pin;
      ext_s2_reg  <= ext_s1_reg;
      ext_s3_reg  <= ext_s2_reg;
      ext_raw_reg <= ext_clk_pin;
      gate_reg    <= gate_pin;
    end
  end

endmodule

// File: verilog/tick_prescaler.sv
// selectable 1:1 / 1:8 / 1:64 / 1:256 tick divider
`timescale 1ns/1ps
module tick_prescaler (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       clear,
  input  wire logic [1:0] prescale_select,
  input  wire logic       tick_in,
  output logic            tick_out
);

  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic [7:0] limit;

  // ==========================================================
  // ratio decode
  always_comb begin
    unique case (prescale_select)
      2'b00: limit = gated_timer_pkg::PRESCALE_LIM_1;
      2'b01: limit = gated_timer_pkg::PRESCALE_LIM_8;
      2'b10: limit = gated_timer_pkg::PRESCALE_LIM_64;
      2'b11: limit = gated_timer_pkg::PRESCALE_LIM_256;
    endcase
    tick_out = tick_in & (div_reg >= limit);
    div_next = div_reg;
    if (clear) begin
      div_next = 8'h00;
    end else if (tick_out) begin
      div_next = 8'h00;
    end else if (tick_in) begin
      div_next = div_reg + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_next;
    end
  end

endmodule
